// file: src/fdr_pkg.sv
// Constants shared by the floppy read data recovery block
package fdr_pkg;
    // APB register byte addresses
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_SYNC     = 8'h04;
    localparam logic [7:0]  ADDR_STAT     = 8'h08;
    // Field positions
    localparam int          CTRL_EN_BIT   = 0;
    localparam int          CTRL_FRST_BIT = 1;
    localparam int          STAT_SYNC_BIT = 0;
    localparam int          STAT_FAST_BIT = 1;
    localparam int          STAT_CRC_BIT  = 2;
    localparam int          STAT_NRZ_BIT  = 3;
    // Values after reset and loads
    localparam logic [7:0]  SYNC_RST      = 8'hF5;
    localparam logic [3:0]  REF_LOAD      = 4'h9;
    localparam logic [3:0]  REF_LAST      = 4'hF;
    localparam logic [3:0]  REF_PRE_RISE  = 4'h7;
    localparam logic [15:0] CRC_PRESET    = 16'hFFFF;
    localparam logic [15:0] CRC_POLY      = 16'h1021;
    // Timing: one recovered cell is 2 us
    localparam int          CELL_NS       = 2000;
    localparam int          CRC_WIN_NS    = 32000;
    localparam int          DELAY_NS      = 16000;
    localparam int          DELAY_STAGES  = DELAY_NS / CELL_NS;
    localparam logic [4:0]  CRC_WIN_CELLS = 5'(CRC_WIN_NS / CELL_NS);
    localparam int          SWITCH_BIT    = 3;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_HUNT  = 2'b01,
        ST_ALIGN = 2'b10,
        ST_DATA  = 2'b11
    } fdr_state_t;
endpackage : fdr_pkg

// file: src/fdr_crc_if.sv
// Carrier between sequencer and CRC generator
`timescale 1ns/1ps
`default_nettype none
interface fdr_crc_if;
    logic bit_in;
    logic shift;
    logic preset;
    logic zero;
    modport gen (input bit_in, input shift, input preset, output zero);
    modport ctl (output bit_in, output shift, output preset, input zero);
endinterface : fdr_crc_if
`default_nettype wire

// file: src/fdr_crc.sv
// Serial CRC generator fed with the delayed data bits
`timescale 1ns/1ps
`default_nettype none
module fdr_crc (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic ce,
    fdr_crc_if.gen    crc
);
    logic [15:0] crc_reg;
    logic        fb;

    assign fb = crc_reg[15] ^ crc.bit_in;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            crc_reg <= fdr_pkg::CRC_PRESET;
        end else if (ce) begin
            if (crc.preset) begin
                crc_reg <= fdr_pkg::CRC_PRESET;
            end else if (crc.shift) begin
                crc_reg <= {crc_reg[14:0], 1'b0} ^ (fb ? fdr_pkg::CRC_POLY : 16'h0000);
            end
        end
    end

    assign crc.zero = (crc_reg == 16'h0000);
endmodule : fdr_crc
`default_nettype wire

// file: src/fdr_top.sv
// Floppy read data separator and read formatter sequencer
// How it works
// RQ1 - Raw pulse makes one-VCO-period load pulse
// RQ2 - Load pulse presets counter nine, sets capture
// RQ3 - Counter bit 3 rises within fifteen periods
// RQ4 - Carry every sixteen periods; divider feeds detector
// RQ5 - Bit 3 falling edge clears capture flop
// RQ6 - Capture resampled by bit 3 gives NRZ
// RQ7 - Drive never omits two pulses running
// RQ8 - Drive delivers next pulse within 32 us
// RQ9 - Eight stage line delays data 16 us
// RQ10 - Sync bits shifted in also reach CRC
// RQ11 - Hunt at 500 kHz against mark half
// RQ12 - Match raises sync match output
// RQ13 - Host checks second mark half itself
// RQ14 - After second half read clock 250 kHz
// RQ15 - CRC shifts data bits only
// RQ16 - CRC result shown for 32 us
// RQ17 - Formatter reset clears sync, selects 500 kHz
// RQ18 - Host prepares drive and adapter first
// RQ19 - Sync match lasts one read clock
// RQ20 - Eight counts after sync latch select 250 kHz
// RQ21 - Read clock selection switches without glitch
// RQ22 - Reset leaves sync cleared, 500 kHz chosen
`timescale 1ns/1ps
`default_nettype none
module fdr_top (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        raw_read,
    input  wire logic        vco_in,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             load_n,
    output logic             recov_clk,
    output logic             pd_ref,
    output logic             pd_var,
    output logic             nrz_data,
    output logic             delayed_data,
    output logic             read_clk_tick,
    output logic             rate_fast,
    output logic             sync_match_out,
    output logic             crc_ok
);
    fdr_crc_if crc_bus ();

    fdr_crc u_crc (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .crc     (crc_bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, three stages, change accepted when 2 and 3 agree
    // VCO high lasts under two clocks, so its tick is a stage 2 to 3 rise
    logic [2:0] raw_sync_reg;
    logic [2:0] vco_sync_reg;
    logic       raw_stable_reg;
    logic       raw_edge;
    logic       vco_tick;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            raw_sync_reg   <= 3'h0;
            vco_sync_reg   <= 3'h0;
            raw_stable_reg <= 1'b0;
        end else if (ce) begin
            raw_sync_reg <= {raw_sync_reg[1:0], raw_read};
            vco_sync_reg <= {vco_sync_reg[1:0], vco_in};
            if (raw_sync_reg[1] == raw_sync_reg[2]) begin
                raw_stable_reg <= raw_sync_reg[2];
            end
        end
    end

    assign raw_edge = raw_sync_reg[1] & raw_sync_reg[2] & ~raw_stable_reg;
    assign vco_tick = vco_sync_reg[1] & ~vco_sync_reg[2];

    ////////////////////////////////////////////////////////////////////////
    // Data separator on VCO ticks
    logic       pend_reg;
    logic       ff1_reg;
    logic       ff2_reg;
    logic       load_pulse;
    logic [3:0] ref_cnt_reg;
    logic [3:0] ref_cnt_next;
    logic [3:0] var_cnt_reg;
    logic       cap_reg;
    logic       nrz_reg;
    logic       pd_ref_reg;
    logic       pd_var_reg;
    logic       bit3_rise;
    logic       bit3_fall;
    logic       edge500;
    logic       fall500;
    logic       load_n_reg;

    assign load_pulse   = ff1_reg & ~ff2_reg;
    assign ref_cnt_next = load_pulse ? fdr_pkg::REF_LOAD : ref_cnt_reg + 4'h1;
    assign bit3_rise    = ~ref_cnt_reg[3] & ref_cnt_next[3];
    assign bit3_fall    = ref_cnt_reg[3] & ~ref_cnt_next[3];
    assign edge500      = ce & vco_tick & bit3_rise;
    assign fall500      = ce & vco_tick & bit3_fall;

    // A raw edge between ticks is held so it is never lost
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend_reg <= 1'b0;
            ff1_reg  <= 1'b0;
            ff2_reg  <= 1'b0;
            load_n_reg <= 1'b1;
        end else if (ce) begin
            if (raw_edge) begin
                pend_reg <= 1'b1;
            end else if (vco_tick) begin
                pend_reg <= 1'b0;
            end
            if (vco_tick) begin
                ff1_reg <= pend_reg; // RQ1
                ff2_reg <= ff1_reg; // RQ1
                load_n_reg <= ~(pend_reg & ~ff1_reg); // RQ1
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ref_cnt_reg <= 4'h0;
            var_cnt_reg <= 4'h0;
            pd_ref_reg  <= 1'b0;
            pd_var_reg  <= 1'b0;
        end else if (ce && vco_tick) begin
            ref_cnt_reg <= ref_cnt_next; // RQ2 RQ3
            var_cnt_reg <= var_cnt_reg + 4'h1;
            pd_ref_reg  <= ~load_pulse && (ref_cnt_reg == fdr_pkg::REF_LAST); // RQ4
            pd_var_reg  <= (var_cnt_reg == fdr_pkg::REF_LAST); // RQ4
        end
    end

    // Set by a data pulse wins over the clock-edge clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cap_reg <= 1'b0;
            nrz_reg <= 1'b0;
        end else if (ce && vco_tick) begin
            if (load_pulse) begin
                cap_reg <= 1'b1; // RQ2
            end else if (bit3_fall) begin
                cap_reg <= 1'b0; // RQ5
            end
            // Taken as the clear lands, else the cell's pulse is already gone
            if (bit3_fall) begin
                nrz_reg <= cap_reg; // RQ6
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Delay line toward the CRC, also carries the sync bits
    logic [fdr_pkg::DELAY_STAGES-1:0] dly_reg;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dly_reg <= '0;
        end else if (fall500) begin
            dly_reg <= {dly_reg[fdr_pkg::DELAY_STAGES-2:0], nrz_reg}; // RQ9 RQ10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers over APB
    logic        read_en_reg;
    logic        frst_pulse;
    logic [7:0]  sync_pat_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        acc;
    logic        wr_go;
    logic        mapped;
    fdr_pkg::fdr_state_t state_reg;
    logic        crc_ok_reg;

    assign acc    = psel & penable;
    assign wr_go  = acc & pready_reg & pwrite;
    assign mapped = (paddr == fdr_pkg::ADDR_CTRL) || (paddr == fdr_pkg::ADDR_SYNC)
                 || (paddr == fdr_pkg::ADDR_STAT);
    assign frst_pulse = wr_go && (paddr == fdr_pkg::ADDR_CTRL)
                     && pwdata[fdr_pkg::CTRL_FRST_BIT];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
        end else if (ce) begin
            pready_reg  <= acc & ~pready_reg;
            pslverr_reg <= acc & ~pready_reg & ~mapped;
            prdata_reg  <= 32'h00000000;
            if (acc && !pready_reg && !pwrite) begin
                case (paddr)
                    fdr_pkg::ADDR_CTRL: prdata_reg <= {31'h0, read_en_reg};
                    fdr_pkg::ADDR_SYNC: prdata_reg <= {24'h0, sync_pat_reg};
                    fdr_pkg::ADDR_STAT: prdata_reg <= {28'h0, nrz_reg, crc_ok_reg,
                                                       state_reg != fdr_pkg::ST_DATA,
                                                       state_reg[1]};
                    default:            prdata_reg <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            read_en_reg  <= 1'b0;
            sync_pat_reg <= fdr_pkg::SYNC_RST;
        end else if (ce && wr_go) begin
            if (paddr == fdr_pkg::ADDR_CTRL) begin
                read_en_reg <= pwdata[fdr_pkg::CTRL_EN_BIT];
            end
            if (paddr == fdr_pkg::ADDR_SYNC) begin
                sync_pat_reg <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read sequencer: hunt at 2X, align eight counts, then 1X data
    logic [3:0] div_reg;
    logic [3:0] div_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic       rd_tick;
    logic       match_now;
    logic       sm_reg;
    logic       rd_tick_reg;

    assign div_next   = div_reg + 4'h1;
    // Selection changes to 1X only with a 500 kHz edge, so no runt tick
    assign rd_tick    = edge500 & ((state_reg != fdr_pkg::ST_DATA) | div_next[0]); // RQ21
    assign shift_next = {shift_reg[6:0], nrz_reg};
    assign match_now  = (shift_next == sync_pat_reg); // RQ11

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= fdr_pkg::ST_IDLE; // RQ22
            div_reg   <= 4'h0;
        end else if (ce) begin
            if (!read_en_reg) begin
                state_reg <= fdr_pkg::ST_IDLE;
            end else if (frst_pulse) begin
                state_reg <= fdr_pkg::ST_HUNT; // RQ17
                div_reg   <= 4'h0;
            end else begin
                case (state_reg)
                    fdr_pkg::ST_IDLE: state_reg <= fdr_pkg::ST_IDLE;
                    fdr_pkg::ST_HUNT: begin
                        if (edge500 && sm_reg) begin
                            state_reg <= fdr_pkg::ST_ALIGN; // RQ20
                        end
                    end
                    fdr_pkg::ST_ALIGN: begin
                        if (edge500) begin
                            div_reg <= div_next; // RQ20
                            if (div_next[fdr_pkg::SWITCH_BIT]) begin
                                state_reg <= fdr_pkg::ST_DATA; // RQ14 RQ20
                            end
                        end
                    end
                    fdr_pkg::ST_DATA: begin
                        if (edge500) begin
                            div_reg <= div_next;
                        end
                    end
                    default: state_reg <= fdr_pkg::ST_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            shift_reg   <= 8'h00;
            sm_reg      <= 1'b0;
            rd_tick_reg <= 1'b0;
        end else if (ce) begin
            rd_tick_reg <= rd_tick;
            if (rd_tick) begin
                shift_reg <= shift_next;
                sm_reg    <= (state_reg == fdr_pkg::ST_HUNT) && match_now; // RQ12 RQ19
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // CRC gating and result window
    logic [4:0] win_reg;
    logic       crc_done_reg;

    assign crc_bus.bit_in = dly_reg[fdr_pkg::DELAY_STAGES-1];
    assign crc_bus.preset = frst_pulse; // RQ17
    // Only every other 500 kHz edge once latched: data bits, no clock bits
    assign crc_bus.shift  = edge500 & state_reg[1] & div_next[0]; // RQ15

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            win_reg      <= 5'h00;
            crc_ok_reg   <= 1'b0;
            crc_done_reg <= 1'b0;
        end else if (ce) begin
            if (frst_pulse) begin
                win_reg      <= 5'h00;
                crc_ok_reg   <= 1'b0;
                crc_done_reg <= 1'b0;
            end else if (edge500) begin
                if (state_reg == fdr_pkg::ST_DATA && crc_bus.zero && !crc_done_reg) begin
                    win_reg      <= fdr_pkg::CRC_WIN_CELLS; // RQ16
                    crc_ok_reg   <= 1'b1;
                    crc_done_reg <= 1'b1;
                end else if (win_reg != 5'h00) begin
                    win_reg    <= win_reg - 5'h01;
                    crc_ok_reg <= (win_reg != 5'h01); // RQ16
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops except rate_fast, decoded from two state_reg bits
    assign prdata         = prdata_reg;
    assign pready         = pready_reg;
    assign pslverr        = pslverr_reg;
    assign load_n         = load_n_reg;
    assign recov_clk      = ref_cnt_reg[3];
    assign pd_ref         = pd_ref_reg;
    assign pd_var         = pd_var_reg;
    assign nrz_data       = nrz_reg;
    assign delayed_data   = dly_reg[fdr_pkg::DELAY_STAGES-1];
    assign read_clk_tick  = rd_tick_reg;
    assign rate_fast      = ~(state_reg[0] & state_reg[1]);
    assign sync_match_out = sm_reg;
    assign crc_ok         = crc_ok_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    load_width_a: assert property (ce && vco_tick && load_pulse |=> !load_pulse) // RQ1
        else $error("load pulse longer than one VCO period");
    ref_load_a: assert property (ce && vco_tick && load_pulse |=> ref_cnt_reg == 4'h9 && cap_reg) // RQ2
        else $error("load did not preset counter or set capture");
    bit3_rise_a: assert property (ce && vco_tick && load_pulse // RQ3
        |-> ##[0:64] (ce && vco_tick && bit3_rise))
        else $error("bit 3 did not rise after load");
    carry_out_a: assert property (ce && vco_tick && !load_pulse && ref_cnt_reg == 4'hF
        |=> pd_ref_reg && ref_cnt_reg == 4'h0) // RQ4
        else $error("carry missing at terminal count");
    cap_clear_a: assert property (ce && vco_tick && !load_pulse && ref_cnt_reg == 4'hF
        |=> !cap_reg) // RQ5
        else $error("capture not cleared on bit 3 fall");
    nrz_sample_a: assert property (fall500 |=> nrz_reg == $past(cap_reg)) // RQ6
        else $error("NRZ not taken from capture");
    delay_line_a: assert property (fall500 |=> dly_reg[0] == $past(nrz_reg)
        && dly_reg[7] == $past(dly_reg[6])) // RQ9
        else $error("delay line did not shift");
    sync_hit_a: assert property (ce && rd_tick && state_reg == fdr_pkg::ST_HUNT && match_now
        |=> sm_reg) // RQ12
        else $error("sync match not raised");
    rate_switch_a: assert property (ce && read_en_reg && !frst_pulse && edge500
        && state_reg == fdr_pkg::ST_ALIGN && div_reg == 4'h7 |=> !rate_fast) // RQ14
        else $error("read clock not switched after eight counts");
    frst_clear_a: assert property (ce && read_en_reg && frst_pulse
        |=> state_reg == fdr_pkg::ST_HUNT && rate_fast && !crc_ok_reg) // RQ17
        else $error("formatter reset did not restore hunt");
    reset_idle_a: assert property ($fell(rst) |-> state_reg == fdr_pkg::ST_IDLE
        && rate_fast && !sm_reg) // RQ22
        else $error("reset state wrong");
    crc_win_a: assert property ($rose(crc_ok_reg) |-> win_reg == 5'd16) // RQ16
        else $error("CRC window not 32 us");

    sync_seen_c: cover property (sm_reg && state_reg == fdr_pkg::ST_HUNT);
    data_phase_c: cover property ($rose(state_reg == fdr_pkg::ST_DATA));
    crc_good_c: cover property ($rose(crc_ok_reg));
endmodule : fdr_top
`default_nettype wire

// file: testbench/fdr_drive_model.sv
// Behavioural drive: free running VCO and raw cell pulses
`timescale 1ns/1ps
`default_nettype none
module fdr_drive_model (
    output logic raw_read,
    output logic vco_in
);
    // Ideal lock: 8 MHz, so 16 ticks make one 2 us cell
    localparam realtime VCO_HALF = 62.5;

    logic [7:0] cells_q[$];
    logic [7:0] cur;

    ////////////////////////////////////////////////////////////////
    initial begin
        vco_in = 1'b0;
        forever #(VCO_HALF) vco_in = ~vco_in;
    end

    ////////////////////////////////////////////////////////////////
    // Idle stream is all pulses, so a gap is never two cells long
    initial begin
        raw_read = 1'b0;
        forever begin
            cur = (cells_q.size() != 0) ? cells_q.pop_front() : 8'hFF;
            for (int i = 7; i >= 0; i--) begin
                @(posedge vco_in);
                #30;
                raw_read = cur[i];
                #200;
                raw_read = 1'b0;
                // Pulse outlasts one tick, hence 14 more to close the cell
                repeat (14) @(posedge vco_in);
            end
        end
    end
endmodule : fdr_drive_model
`default_nettype wire

// file: testbench/tb_floppy_read_data_recovery.sv
// Self-checking bench for the floppy read data recovery block
`timescale 1ns/1ps
`default_nettype none
module tb_floppy_read_data_recovery;
    typedef struct {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [31:0] exp;
        logic [31:0] mask;
        logic        err;
    } fdr_row_t;

    logic        ref_clk;
    logic        rst;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] rd;
    logic        er;
    wire  [31:0] prdata;
    wire         pready, pslverr, load_n, recov_clk, pd_ref, pd_var, nrz_data;
    wire         delayed_data, read_clk_tick, rate_fast, sync_match_out, crc_ok;
    wire         raw_read, vco_in;
    int          num_errors = 0;
    int          n_checks = 0;
    int          n, n2, a, b, t_fast, t_slow;
    fdr_row_t    rows[10];

    fdr_drive_model drv (.raw_read(raw_read), .vco_in(vco_in));

    fdr_top DUT (
        .ref_clk(ref_clk), .rst(rst), .ce(ce), .raw_read(raw_read), .vco_in(vco_in),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .load_n(load_n),
        .recov_clk(recov_clk), .pd_ref(pd_ref), .pd_var(pd_var), .nrz_data(nrz_data),
        .delayed_data(delayed_data), .read_clk_tick(read_clk_tick), .rate_fast(rate_fast),
        .sync_match_out(sync_match_out), .crc_ok(crc_ok)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] lo, input logic [31:0] hi);
        n_checks++;
        if (((seen >= lo) && (seen <= hi)) !== 1'b1) begin
            num_errors++;
            $display("BAD %s expected %0h..%0h seen %0h", name, lo, hi, seen);
        end
    endtask : check

    function automatic logic sig(input int k);
        case (k)
            0: sig = load_n;
            1: sig = recov_clk;
            2: sig = pd_ref;
            3: sig = nrz_data;
            4: sig = delayed_data;
            5: sig = sync_match_out;
            6: sig = rate_fast;
            7: sig = read_clk_tick;
            default: sig = pd_var;
        endcase
    endfunction : sig

    // Counts settled cycles until the watched output takes the value
    task automatic wait_for(input int k, input logic v, output int c);
        c = 0;
        while (sig(k) !== v) begin
            @(posedge ref_clk);
            #1;
            c++;
            if (c > 20000) begin
                num_errors++;
                $display("BAD timeout on output %0d", k);
                stop_test();
            end
        end
    endtask : wait_for

    task automatic period(input int k, output int p);
        int c;
        wait_for(k, 1'b0, c);
        wait_for(k, 1'b1, c);
        wait_for(k, 1'b0, p);
        wait_for(k, 1'b1, c);
        p = p + c;
    endtask : period

    // Read data and pready are taken before this edge's updates land
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int k;
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 40);
        q = prdata;
        e = pslverr;
        if (k >= 40) begin
            num_errors++;
            $display("BAD apb ready never came");
            stop_test();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    ////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rows = '{
            '{1'b0, fdr_pkg::ADDR_SYNC, 32'h0, 32'h000000F5, 32'hFFFFFFFF, 1'b0},
            '{1'b0, fdr_pkg::ADDR_CTRL, 32'h0, 32'h00000000, 32'hFFFFFFFF, 1'b0},
            '{1'b0, fdr_pkg::ADDR_STAT, 32'h0, 32'h00000002, 32'h00000007, 1'b0},
            '{1'b0, 8'h0C, 32'h0, 32'h00000000, 32'hFFFFFFFF, 1'b1},
            '{1'b1, 8'h0C, 32'hFFFFFFFF, 32'h0, 32'h0, 1'b1},
            '{1'b1, fdr_pkg::ADDR_SYNC, 32'h5A, 32'h0, 32'h0, 1'b0},
            '{1'b0, fdr_pkg::ADDR_SYNC, 32'h0, 32'h0000005A, 32'hFFFFFFFF, 1'b0},
            '{1'b1, fdr_pkg::ADDR_SYNC, 32'hF5, 32'h0, 32'h0, 1'b0},
            '{1'b1, fdr_pkg::ADDR_CTRL, 32'h3, 32'h0, 32'h0, 1'b0},
            '{1'b0, fdr_pkg::ADDR_CTRL, 32'h0, 32'h00000001, 32'hFFFFFFFF, 1'b0}};
        repeat (11) @(posedge ref_clk);
        #1;
        check("rate_fast", 32'(rate_fast), 1, 1);
        check("sync_match_out", 32'(sync_match_out), 0, 0);
        check("load_n", 32'(load_n), 1, 1);
        check("crc_ok", 32'(crc_ok), 0, 0);
        @(posedge ref_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].wdata, rd, er);
            check("pslverr", 32'(er), 32'(rows[i].err), 32'(rows[i].err));
            if (!rows[i].wr) check("prdata", rd & rows[i].mask, rows[i].exp, rows[i].exp);
        end
        // Read enable already set, so this formatter reset starts the hunt
        apb(1'b1, fdr_pkg::ADDR_CTRL, 32'h3, rd, er);
        period(2, n);
        check("pd_ref period", 32'(n), 48, 52);
        period(8, n);
        check("pd_var period", 32'(n), 48, 52);
        period(1, n);
        check("recov_clk period", 32'(n), 48, 52);
        wait_for(0, 1'b0, n);
        wait_for(0, 1'b1, n);
        check("load_n width", 32'(n), 2, 4);
        check("nrz idle", 32'(nrz_data), 1, 1);
        period(7, t_fast);
        // Mark first half, then second half of the mark
        drv.cells_q.push_back(8'hF5);
        drv.cells_q.push_back(8'h7E);
        fork
            begin
                wait_for(3, 1'b0, a);
                wait_for(4, 1'b0, b);
                check("delay lag", 32'(b), 398, 402);
            end
            begin
                wait_for(3, 1'b0, n);
                wait_for(3, 1'b1, n);
                check("nrz gap", 32'(n), 48, 52);
                wait_for(5, 1'b1, n);
                wait_for(5, 1'b0, n);
                wait_for(6, 1'b0, n2);
                check("sync width", 32'(n), 48, 52);
                check("switch delay", 32'(n + n2), 395, 455);
            end
        join
        period(7, t_slow);
        check("slow tick", 32'(t_slow), 32'(2 * t_fast - 2), 32'(2 * t_fast + 2));
        check("crc_ok bad field", 32'(crc_ok), 0, 0);
        apb(1'b1, fdr_pkg::ADDR_CTRL, 32'h3, rd, er);
        wait_for(6, 1'b1, n);
        check("rate restore", 32'(n), 0, 3);
        apb(1'b0, fdr_pkg::ADDR_STAT, 32'h0, rd, er);
        check("sync latch clear", rd & 32'h3, 2, 2);
        stop_test();
    end
endmodule : tb_floppy_read_data_recovery
`default_nettype wire
